// >>> rtl/e1tfo_frame_insert.sv
// e1 transmit frame overhead insertion with axi4-lite registers
//
// Functional notes
// - no crc: first bit to fas, second nfas
// - crc, error report off: bits to e-bits
// - crc with error report: ignore both bits
// - alignment, extra disables and signaling selects clear: overwrite ts16 extra bits
// - interrupt only for enabled set flags
// - reading status clears all flags
// - signaling flag after frame 0 ends
// - fas flag on each fas boundary
// - multiframe flag after frame 0 ends
// - sub-multiframe flag after its frame 0
// - selector picks national bit 4 to 8
// - per-bit enables gate codeword replacement
// - codeword bits go into each sub-multiframe
// - codeword takes effect at next sub-multiframe
// - alignment disable passes data unchanged
// - replacement off: bit from data or hdlc
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module e1tfo_frame_insert
  import e1tfo_pkg::*;
#(
  parameter int BIT_DIVIDE = BIT_DIV
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic transmitSerialDataIn,
  input wire logic hdlcInsertSel,
  input wire logic hdlcInsertBit,
  output logic txLineData,
  output logic txMfStart,
  output logic irqN
);
  // software registers
  logic [7:0] cfg; // frame generator configuration
  logic [7:0] intlBits; // international bit values
  logic [7:0] extraBits; // ts16 extra bit values
  logic [7:0] irqEn; // boundary interrupt enables
  logic [7:0] cwSel; // national codeword selector
  logic [7:0] cwVal; // codeword as written
  logic [7:0] cwActive; // codeword in use this sub-multiframe
  logic [7:0] flags; // sticky boundary flags
  // frame timing
  logic [7:0] divCnt; // system clocks per line bit
  logic bitEn; // one line bit per pulse
  logic [7:0] bitCnt; // bit within frame
  logic [3:0] frm; // frame within multiframe
  logic [3:0] crc; // running crc-4
  logic [3:0] crcHold; // crc of previous sub-multiframe
  logic txInMeta; // first stage, read only by txInSync
  logic txInSync; // synchronised serial data
  logic next_txData; // bit about to go out
  // named control bits
  logic frameAlignDisable, intlReplaceDisable, extraBitDisable;
  logic signalingSourceSelHi, signalingSourceSelLo;
  logic crcMultiframeGenEn, farEndErrorDisable;
  logic [2:0] nationalBitSelector;
  logic [1:0] cwIdx; // codeword bit index in sub-multiframe
  logic ts0, ts16, fasFrm, lastBit, smfStart, crcActive, xActive;
  logic [2:0] bitPos;
  logic [7:0] evt; // boundary events this cycle
  logic [3:0] crcNext;
  logic crcIn;
  // bus decode
  logic [9:0] wrIdx, rdIdx;
  logic wrEn, wrHit, rdHit, rdStatus, clrWr;
  logic [7:0] rdData, clrMask;

  assign frameAlignDisable = cfg[CFG_FA_DIS];
  assign intlReplaceDisable = cfg[CFG_INTL_DIS];
  assign extraBitDisable = cfg[CFG_X_DIS];
  assign signalingSourceSelHi = cfg[CFG_SIG_HI];
  assign signalingSourceSelLo = cfg[CFG_SIG_LO];
  assign crcMultiframeGenEn = cfg[CFG_CRC_GEN];
  assign farEndErrorDisable = cfg[CFG_FEB_DIS];
  assign nationalBitSelector = cwSel[SEL_MSB:SEL_LSB];
  assign bitPos = bitCnt[2:0];
  assign ts0 = bitCnt[7:3] == 5'h00;
  assign ts16 = bitCnt[7:3] == TS_SIG;
  assign fasFrm = !frm[0];
  assign lastBit = &bitCnt;
  assign cwIdx = frm[2:1];
  assign smfStart = (bitCnt == 8'h00) && (frm[2:0] == 3'h0);
  // crc framing only counts with alignment and replacement on
  assign crcActive = crcMultiframeGenEn && !frameAlignDisable
    && !intlReplaceDisable;
  assign xActive = !frameAlignDisable && !extraBitDisable
    && !signalingSourceSelHi && !signalingSourceSelLo;

  // input pin synchroniser
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txInMeta <= 1'b0;
      txInSync <= 1'b0;
    end else begin
      txInMeta <= transmitSerialDataIn;
      txInSync <= txInMeta;
    end
  end

  // line bit divider
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      divCnt <= 8'h00;
      bitEn <= 1'b0;
    end else if (divCnt == 8'(BIT_DIVIDE - 1)) begin
      divCnt <= 8'h00;
      bitEn <= 1'b1;
    end else begin
      divCnt <= divCnt + 8'h01;
      bitEn <= 1'b0;
    end
  end

  // bit and frame counters
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bitCnt <= 8'h00;
      frm <= 4'h0;
    end else if (bitEn) begin
      bitCnt <= bitCnt + 8'h01;
      if (lastBit) begin
        frm <= frm + 4'h1;
      end
    end
  end

  // overhead insertion for the bit now due
  always_comb begin
    next_txData = txInSync;
    if (frameAlignDisable) begin
      next_txData = txInSync;
    end else if (ts0 && bitPos == 3'h0) begin
      if (intlReplaceDisable) begin
        // own data, or hdlc if it claims this bit
        next_txData = hdlcInsertSel ? hdlcInsertBit : txInSync;
      end else if (!crcMultiframeGenEn) begin
        next_txData = fasFrm ? intlBits[INTL_FIRST]
          : intlBits[INTL_SECOND];
      end else if (fasFrm) begin
        // crc bits of the previous sub-multiframe
        next_txData = crcHold[2'(CW_EN_TOP - cwIdx)];
      end else if (frm < 4'hC) begin
        next_txData = MFA_WORD[3'(3'h5 - frm[3:1])];
      end else if (farEndErrorDisable) begin
        next_txData = frm[1] ? intlBits[INTL_SECOND]
          : intlBits[INTL_FIRST];
      end else begin
        next_txData = 1'b1;
      end
    end else if (ts0 && fasFrm) begin
      next_txData = FAS_WORD[3'(3'h7 - bitPos)];
    end else if (ts0 && bitPos == 3'h1) begin
      next_txData = 1'b1; // nfas marker bit
    end else if (ts0 && !intlReplaceDisable
        && nationalBitSelector >= SEL_FIRST_VALID
        && bitPos == nationalBitSelector) begin
      if (cwActive[3'(3'h7 - {1'b0, cwIdx})]) begin
        next_txData = cwActive[2'(CW_EN_TOP - cwIdx)];
      end
    end else if (ts16 && frm == 4'h0 && xActive) begin
      if (bitPos == POS_X5) begin
        next_txData = extraBits[X_BIT5];
      end else if (bitPos == POS_X7) begin
        next_txData = extraBits[X_BIT7];
      end else if (bitPos == POS_X8) begin
        next_txData = extraBits[X_BIT8];
      end
    end
  end

  // crc-4 over the outgoing bits with c-bit slots as zero
  assign crcIn = (ts0 && bitPos == 3'h0 && fasFrm) ? 1'b0 : next_txData;
  assign crcNext = {crc[2:0], 1'b0}
    ^ ((crc[3] ^ crcIn) ? CRC_POLY : 4'h0);

  // crc register and per sub-multiframe result
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crc <= 4'h0;
      crcHold <= 4'h0;
    end else if (bitEn) begin
      if (lastBit && frm[2:0] == 3'h7) begin
        crcHold <= crcNext;
        crc <= 4'h0;
      end else begin
        crc <= crcNext;
      end
    end
  end

  // line outputs, registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txLineData <= 1'b1;
      txMfStart <= 1'b0;
    end else if (bitEn) begin
      txLineData <= next_txData;
      txMfStart <= (bitCnt == 8'h00) && (frm == 4'h0);
    end
  end

  // codeword staged at every sub-multiframe start
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cwActive <= RST_CW_VAL;
    end else if (bitEn && smfStart) begin
      cwActive <= cwVal;
    end
  end

  // boundary events at the last bit of a frame
  always_comb begin
    evt = 8'h00;
    if (bitEn && lastBit && !frameAlignDisable) begin
      evt[FLAG_FAS] = fasFrm;
      evt[FLAG_SIG] = frm == 4'h0;
      evt[FLAG_MF] = crcActive && frm == 4'h0;
      evt[FLAG_SMF] = crcActive && frm[2:0] == 3'h0;
    end
  end

  // sticky flags: a new event beats a clear
  assign clrMask = ({8{rdStatus}}
    | (clrWr ? wdata[7:0] : 8'h00));
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags <= 8'h00;
    end else begin
      flags <= (evt | (flags & ~clrMask)) & MASK_FLAGS;
    end
  end

  // active-low interrupt, one clock behind the flags
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqN <= 1'b1;
    end else begin
      irqN <= ~|(flags & irqEn);
    end
  end

  // bus address decode
  assign wrIdx = awaddr[11:2];
  assign rdIdx = araddr[11:2];
  assign wrEn = awready && awvalid && wvalid;
  assign wrHit = wrIdx inside {IDX_CONFIG, IDX_INTL, IDX_EXTRA,
    IDX_IRQ_EN, IDX_STATUS, IDX_CW_SEL, IDX_CW_VAL, IDX_IRQ_CLR};
  assign clrWr = wrEn && wstrb[0] && wrIdx == IDX_IRQ_CLR;
  assign rdStatus = arready && arvalid && rdIdx == IDX_STATUS;

  // write channel: both address and data taken together
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (!bvalid && !awready && awvalid && wvalid) begin
        awready <= 1'b1;
        wready <= 1'b1;
      end else begin
        awready <= 1'b0;
        wready <= 1'b0;
      end
      if (wrEn) begin
        bvalid <= 1'b1;
        bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // register writes, low byte lane only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg <= RST_CONFIG;
      intlBits <= RST_INTL;
      extraBits <= RST_EXTRA;
      irqEn <= RST_IRQ_EN;
      cwSel <= RST_CW_SEL;
      cwVal <= RST_CW_VAL;
    end else if (wrEn && wstrb[0]) begin
      case (wrIdx)
        IDX_CONFIG: cfg <= wdata[7:0] & MASK_CONFIG;
        IDX_INTL: intlBits <= wdata[7:0] & MASK_INTL;
        IDX_EXTRA: extraBits <= wdata[7:0] & MASK_EXTRA;
        IDX_IRQ_EN: irqEn <= wdata[7:0] & MASK_FLAGS;
        IDX_CW_SEL: cwSel <= wdata[7:0] & MASK_CW_SEL;
        IDX_CW_VAL: cwVal <= wdata[7:0];
        default: ; // status and clear have no storage here
      endcase
    end
  end

  // read data mux
  always_comb begin
    rdData = 8'h00;
    rdHit = 1'b1;
    case (rdIdx)
      IDX_CONFIG: rdData = cfg;
      IDX_INTL: rdData = intlBits;
      IDX_EXTRA: rdData = extraBits;
      IDX_IRQ_EN: rdData = irqEn;
      IDX_STATUS: rdData = flags;
      IDX_CW_SEL: rdData = cwSel;
      IDX_CW_VAL: rdData = cwVal;
      IDX_IRQ_CLR: rdData = 8'h00; // write-only
      default: rdHit = 1'b0;
    endcase
  end

  // read channel
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else begin
      arready <= !rvalid && !arready && arvalid;
      if (arready && arvalid) begin
        rvalid <= 1'b1;
        rdata <= {24'h000000, rdData};
        rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_intl_fas: assert property (
    (bitEn && ts0 && bitPos == 3'h0 && fasFrm && !frameAlignDisable
      && !intlReplaceDisable && !crcMultiframeGenEn)
    |=> txLineData == $past(intlBits[INTL_FIRST]))
    else $error("first international bit missing");
  a_e_bits: assert property (
    (bitEn && ts0 && bitPos == 3'h0 && frm[3:2] == 2'h3 && !fasFrm
      && crcActive && farEndErrorDisable)
    |=> txLineData == ($past(frm[1]) ? $past(intlBits[INTL_SECOND])
      : $past(intlBits[INTL_FIRST])))
    else $error("e-bit not from programmed value");
  a_febe_ignore: assert property (
    (bitEn && ts0 && bitPos == 3'h0 && frm == 4'hD && crcActive
      && !farEndErrorDisable) |=> txLineData)
    else $error("programmed bit used despite error report");
  a_extra_bit: assert property (
    (bitEn && ts16 && frm == 4'h0 && xActive && bitPos == POS_X5)
    |=> txLineData == $past(extraBits[X_BIT5]))
    else $error("extra bit not replaced");
  a_irq_level: assert property (
    1'b1 |=> irqN == !(|($past(flags) & $past(irqEn))))
    else $error("interrupt level wrong");
  a_read_clear: assert property (
    (rdStatus && evt == 8'h00) |=> flags == 8'h00)
    else $error("status read did not clear flags");
  a_sig_flag: assert property (
    (bitEn && lastBit && frm == 4'h0 && !frameAlignDisable)
    |=> flags[FLAG_SIG] ##1 !irqN || !irqEn[FLAG_SIG])
    else $error("signaling flag not set");
  a_fas_flag: assert property (
    (bitEn && lastBit && fasFrm && !frameAlignDisable)
    |=> flags[FLAG_FAS])
    else $error("fas flag not set");
  a_mf_flag: assert property (
    (bitEn && lastBit && frm == 4'h0 && crcActive)
    |=> flags[FLAG_MF] && flags[FLAG_SMF])
    else $error("multiframe flag not set");
  a_smf_flag: assert property (
    (bitEn && lastBit && frm == 4'h8 && crcActive)
    |=> flags[FLAG_SMF])
    else $error("sub-multiframe flag not set");
  a_cw_stage: assert property (
    (bitEn && smfStart) |=> cwActive == $past(cwVal))
    else $error("codeword not staged at boundary");
  a_pass_thru: assert property (
    (bitEn && frameAlignDisable) |=> txLineData == $past(txInSync))
    else $error("data not passed through");
endmodule
`default_nettype wire

// >>> rtl/e1tfo_pkg.sv
// shared constants of the e1 transmit overhead insertion block
package e1tfo_pkg;
  // register word indices; byte address is four times the index
  localparam logic [9:0] IDX_CONFIG = 10'h040;
  localparam logic [9:0] IDX_INTL = 10'h042;
  localparam logic [9:0] IDX_EXTRA = 10'h043;
  localparam logic [9:0] IDX_IRQ_EN = 10'h044;
  localparam logic [9:0] IDX_STATUS = 10'h045;
  localparam logic [9:0] IDX_CW_SEL = 10'h046;
  localparam logic [9:0] IDX_CW_VAL = 10'h047;
  localparam logic [9:0] IDX_IRQ_CLR = 10'h04E;
  // configuration register fields
  localparam int CFG_SIG_HI = 6;
  localparam int CFG_SIG_LO = 5;
  localparam int CFG_CRC_GEN = 4;
  localparam int CFG_FA_DIS = 3;
  localparam int CFG_FEB_DIS = 2;
  localparam int CFG_INTL_DIS = 1;
  localparam int CFG_X_DIS = 0;
  // international bit fields
  localparam int INTL_FIRST = 7;
  localparam int INTL_SECOND = 6;
  // extra bit fields and their ts16 bit positions (0 = bit 1)
  localparam int X_BIT5 = 3;
  localparam int X_BIT7 = 1;
  localparam int X_BIT8 = 0;
  localparam logic [2:0] POS_X5 = 3'h4;
  localparam logic [2:0] POS_X7 = 3'h6;
  localparam logic [2:0] POS_X8 = 3'h7;
  // boundary flag positions
  localparam int FLAG_SIG = 4;
  localparam int FLAG_FAS = 3;
  localparam int FLAG_MF = 2;
  localparam int FLAG_SMF = 1;
  // codeword selector and value fields
  localparam int SEL_MSB = 7;
  localparam int SEL_LSB = 5;
  localparam logic [2:0] SEL_FIRST_VALID = 3'h3;
  localparam logic [1:0] CW_EN_TOP = 2'h3;
  // writable bits of each register
  localparam logic [7:0] MASK_CONFIG = 8'h7F;
  localparam logic [7:0] MASK_INTL = 8'hC0;
  localparam logic [7:0] MASK_EXTRA = 8'h0B;
  localparam logic [7:0] MASK_FLAGS = 8'h1E;
  localparam logic [7:0] MASK_CW_SEL = 8'hE0;
  // reset values
  localparam logic [7:0] RST_CONFIG = 8'h60;
  localparam logic [7:0] RST_INTL = 8'hC0;
  localparam logic [7:0] RST_EXTRA = 8'h0B;
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_CW_SEL = 8'h00;
  localparam logic [7:0] RST_CW_VAL = 8'h0F;
  // frame patterns: bits 1..8 msb first, crc-4 polynomial x^4+x+1
  localparam logic [7:0] FAS_WORD = 8'h1B;
  localparam logic [5:0] MFA_WORD = 6'h0B;
  localparam logic [3:0] CRC_POLY = 4'h3;
  localparam logic [4:0] TS_SIG = 5'h10;
  // line bit rate against system clock
  localparam int CLK_KHZ = 200000;
  localparam int LINE_KHZ = 2048;
  localparam int BIT_DIV = CLK_KHZ / LINE_KHZ;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> testbench/e1tfo_frame_insert_test.sv
// self-checking bench: registers, line overhead and interrupt
`timescale 1ns/100ps
`default_nettype none
module e1tfo_frame_insert_test;
  import e1tfo_pkg::*;
  localparam int DIV = 2; // shortened bit period
  localparam logic [9:0] REG_IDX [6] = '{IDX_CONFIG, IDX_INTL, IDX_EXTRA,
    IDX_IRQ_EN, IDX_CW_SEL, IDX_CW_VAL};
  localparam logic [7:0] REG_RST [6] = '{RST_CONFIG, RST_INTL, RST_EXTRA,
    RST_IRQ_EN, RST_CW_SEL, RST_CW_VAL};
  localparam logic [7:0] REG_MSK [6] = '{MASK_CONFIG, MASK_INTL,
    MASK_EXTRA, MASK_FLAGS, MASK_CW_SEL, 8'hFF};
  // line modes under test and their codeword selectors
  localparam logic [7:0] CFG_TAB [6] = '{8'h00, 8'h14, 8'h10, 8'h02,
    8'h01, 8'h08};
  localparam logic [7:0] SEL_TAB [6] = '{8'h60, 8'h80, 8'hA0, 8'hC0,
    8'hE0, 8'h60};
  logic clk, rstn, awvalid, wvalid, bvalid, bready, arvalid, rvalid;
  logic rready, awready, wready, arready, capDone;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic dataLevel, serialIn, hdlcSel, hdlcBit, txLineData, txMfStart;
  logic irqN, lv, hs, hb;
  logic [4095:0] mfBits, mfCopy;
  logic [7:0] cc, ci, cx, cs, cw, ce, m;
  int errors, compares, n;
  e1tfo_frame_insert #(.BIT_DIVIDE(DIV)) e1tfo_frame_insert_i (
    .clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .transmitSerialDataIn(serialIn), .hdlcInsertSel(hdlcSel),
    .hdlcInsertBit(hdlcBit), .txLineData(txLineData),
    .txMfStart(txMfStart), .irqN(irqN));
  e1tfo_line_model #(.DIV(DIV)) e1tfo_line_model_i (
    .clk(clk), .rstn(rstn), .dataLevel(dataLevel), .serialOut(serialIn),
    .txLineData(txLineData), .txMfStart(txMfStart), .mfBits(mfBits),
    .capDone(capDone));
  // 200 mhz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // watchdog over the whole run
  initial begin
    #500000;
    errors++;
    conclude();
  end
  task automatic conclude();
    if (errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // write with both channels offered together, held until taken
  task automatic axiWrite(input logic [9:0] idx, input logic [7:0] val,
    output logic [1:0] resp);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // no cycle count assumed: only the watchdog ends a hung wait
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
  endtask
  task automatic axiRead(input logic [9:0] idx, output logic [31:0] data,
    output logic [1:0] resp);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    data = rdata;
    resp = rresp;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] val);
    logic [1:0] rs;
    axiWrite(idx, val, rs);
    check("bresp", RESP_OKAY, rs);
  endtask
  task automatic rdChk(input logic [9:0] idx, input logic [7:0] exp);
    logic [31:0] dd;
    logic [1:0] rs;
    axiRead(idx, dd, rs);
    check("rresp", RESP_OKAY, rs);
    check("rdata", {24'h0, exp}, dd);
  endtask
  // captured timeslot byte, bit 1 in the msb
  function automatic logic [7:0] lineByte(int f, int ts);
    logic [7:0] b;
    for (int j = 0; j < 8; j++) b[7 - j] = mfCopy[f * 256 + ts * 8 + j];
    return b;
  endfunction
  // expected ts0 of frame f under the current mode
  function automatic logic [7:0] expTs0(int f);
    logic [7:0] w;
    int s;
    int k;
    w = (f % 2 == 0) ? FAS_WORD : {2'b01, {6{lv}}};
    s = int'(cs[SEL_MSB:SEL_LSB]);
    k = (f % 8) / 2;
    if (cc[CFG_FA_DIS]) return {8{lv}};
    if (cc[CFG_INTL_DIS]) w[7] = hs ? hb : lv;
    else if (!cc[CFG_CRC_GEN]) w[7] = ci[f % 2 == 0 ? INTL_FIRST : INTL_SECOND];
    else if (f == 13) w[7] = cc[CFG_FEB_DIS] ? ci[INTL_FIRST] : 1'b1;
    else if (f == 15) w[7] = cc[CFG_FEB_DIS] ? ci[INTL_SECOND] : 1'b1;
    else if (f % 2 == 1) w[7] = MFA_WORD[5 - f / 2];
    if (!cc[CFG_INTL_DIS] && f % 2 == 1 && s >= 3 && cw[7 - k])
      w[7 - s] = cw[3 - k];
    return w;
  endfunction
  // expected ts16 of frame 0
  function automatic logic [7:0] expTs16();
    logic [7:0] w;
    w = {8{lv}};
    if (cc[CFG_FA_DIS] || cc[CFG_X_DIS] || cc[CFG_SIG_HI] || cc[CFG_SIG_LO])
      return w;
    w[7 - POS_X5] = cx[X_BIT5];
    w[7 - POS_X7] = cx[X_BIT7];
    w[7 - POS_X8] = cx[X_BIT8];
    return w;
  endfunction
  // flags raised by one whole multiframe
  function automatic logic [7:0] expFlags();
    if (cc[CFG_FA_DIS]) return 8'h00;
    if (cc[CFG_CRC_GEN] && !cc[CFG_INTL_DIS]) return MASK_FLAGS;
    return (8'h01 << FLAG_SIG) | (8'h01 << FLAG_FAS);
  endfunction
  initial begin
    void'($urandom(37449));
    rstn = 1'b0;
    {awvalid, wvalid, arvalid, hdlcSel, hdlcBit} = 5'h00;
    {bready, rready, dataLevel} = 3'h7;
    {awaddr, araddr, wdata, wstrb} = {24'h000000, 32'h00000000, 4'hF};
    errors = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // reset values, random write, masked read-back
    for (int i = 0; i < 6; i++) begin
      rdChk(REG_IDX[i], REG_RST[i]);
      m = 8'($urandom);
      wr(REG_IDX[i], m);
      rdChk(REG_IDX[i], m & REG_MSK[i]);
    end
    rdChk(IDX_IRQ_CLR, 8'h00);
    axiWrite(10'h048, 8'h55, r);
    check("unmapped bresp", RESP_SLVERR, r);
    axiRead(10'h048, d, r);
    check("unmapped rresp", RESP_SLVERR, r);
    check("unmapped rdata", 32'h0, d);
    // interrupt raised by a fas flag, then cleared by write-one
    wr(IDX_CONFIG, 8'h00);
    wr(IDX_IRQ_EN, 8'h01 << FLAG_FAS);
    rdChk(IDX_STATUS, 8'h00);
    n = 0;
    while (irqN !== 1'b0 && n < 6000) begin
      @(posedge clk);
      n++;
    end
    check("irq raised", 1'b0, irqN);
    wr(IDX_IRQ_CLR, MASK_FLAGS);
    repeat (2) @(posedge clk);
    check("irq cleared", 1'b1, irqN);
    // one multiframe per line mode, checked after it ends
    for (int i = 0; i <= 6; i++) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (capDone !== 1'b1 && n < 10000);
      mfCopy = mfBits;
      if (n >= 10000) errors++;
      @(posedge clk);
      if (i > 0) begin
        for (int f = 8; f < 16; f++) begin
          m = (cc[CFG_CRC_GEN] && !cc[CFG_INTL_DIS] && !cc[CFG_FA_DIS] &&
            f % 2 == 0) ? 8'h7F : 8'hFF;
          check("ts0", expTs0(f) & m, lineByte(f, 0) & m);
        end
        check("ts16", expTs16(), lineByte(0, 16));
        check("irq level", ~|(expFlags() & ce), irqN);
        rdChk(IDX_STATUS, expFlags());
        rdChk(IDX_STATUS, 8'h00);
        check("irq after read", 1'b1, irqN);
      end
      if (i < 6) begin
        // first pass: fas flags of frames 2..14 since the write-one clear
        rdChk(IDX_STATUS, i == 0 ? 8'h01 << FLAG_FAS : 8'h00);
        cc = CFG_TAB[i];
        cs = SEL_TAB[i];
        lv = 1'($urandom);
        hb = 1'($urandom);
        hs = (i == 3);
        ci = {~lv, 1'($urandom), 6'h00};
        cx = {4'h0, ~lv, 1'b0, 1'($urandom), ~lv};
        cw = {1'b1, 3'($urandom), {4{~lv}}};
        ce = 8'($urandom) & MASK_FLAGS;
        dataLevel <= lv;
        hdlcSel <= hs;
        hdlcBit <= hb;
        wr(IDX_CONFIG, cc);
        wr(IDX_INTL, ci);
        wr(IDX_EXTRA, cx);
        wr(IDX_CW_SEL, cs);
        wr(IDX_CW_VAL, cw);
        wr(IDX_IRQ_EN, ce);
      end
    end
    conclude();
  end
endmodule
`default_nettype wire

// >>> testbench/e1tfo_line_model.sv
// line-side capture model and backplane data source
`timescale 1ns/100ps
`default_nettype none
module e1tfo_line_model #(
  parameter int DIV = 2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic dataLevel,
  output logic serialOut,
  input wire logic txLineData,
  input wire logic txMfStart,
  output logic [4095:0] mfBits,
  output logic capDone
);
  logic prevStart; // mf start seen last clock
  int clkCnt; // clocks within one line bit
  int bitIdx; // next bit of the multiframe
  // backplane source: level refreshed every clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serialOut <= 1'b1;
    end else begin
      serialOut <= dataLevel;
    end
  end
  // line sink: one sample per bit, aligned on mf start
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prevStart <= 1'b0;
      clkCnt <= 0;
      bitIdx <= 4096;
      capDone <= 1'b0;
      mfBits <= '0;
    end else begin
      prevStart <= txMfStart;
      capDone <= 1'b0;
      clkCnt <= (clkCnt == DIV - 1) ? 0 : clkCnt + 1;
      if (txMfStart && !prevStart) begin
        // first bit of frame 0
        mfBits[0] <= txLineData;
        bitIdx <= 1;
        clkCnt <= 1;
      end else if (clkCnt == 0 && bitIdx < 4096) begin
        // bit held whole period, sample at its start
        mfBits[bitIdx] <= txLineData;
        bitIdx <= bitIdx + 1;
        capDone <= (bitIdx == 4095);
      end
    end
  end
endmodule
`default_nettype wire
